/* File: src/led_blink_breathe_pwm.v */
// led blink / breathe / general purpose pwm with watchdog, axi4-lite registers
`include "led_pwm_defines.vh"
`default_nettype none

module led_blink_breathe_pwm (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // time bases from outside this clock domain
  input  wire        clk_32k,
  input  wire        clk_48m,
  input  wire        slow_tick_clock,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pin and event
  output reg         led_out,
  output reg         pwm_watchdog_event
);

  localparam [3:0] ST_UP = 4'b0001;
  localparam [3:0] ST_HI = 4'b0010;
  localparam [3:0] ST_DN = 4'b0100;
  localparam [3:0] ST_LO = 4'b1000;

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    input [31:0] mask;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
      merge = merge & mask;
    end
  endfunction

  // three stages: two to synchronise, the third only for the edge detect
  reg [2:0] s32_q;
  reg [2:0] s48_q;
  reg [2:0] s5_q;
  wire      e32 = s32_q[1] & ~s32_q[2];
  wire      e48 = s48_q[1] & ~s48_q[2];
  wire      e5  = s5_q[1] & ~s5_q[2];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s32_q <= 3'h0;
      s48_q <= 3'h0;
      s5_q  <= 3'h0;
    end else begin
      s32_q <= {s32_q[1:0], clk_32k};
      s48_q <= {s48_q[1:0], clk_48m};
      s5_q  <= {s5_q[1:0], slow_tick_clock};
    end
  end

  // register images
  reg [31:0] cfg_q;
  reg [31:0] lim_q;
  reg [31:0] dly_q;
  reg [31:0] stp_q;

  wire [1:0]  mode   = cfg_q[`CFG_MODE_HI:`CFG_MODE_LO];
  wire        csel   = cfg_q[`CFG_CSEL];
  wire [7:0]  watchdog_reload_value  = cfg_q[`CFG_WDT_HI:`CFG_WDT_LO];
  wire [7:0]  dmin   = lim_q[`LIM_MIN_HI:`LIM_MIN_LO];
  wire [7:0]  dmax   = lim_q[`LIM_MAX_HI:`LIM_MAX_LO];
  wire [11:0] ld     = dly_q[`DLY_LD_HI:`DLY_LD_LO];
  wire [11:0] hd     = dly_q[`DLY_HD_HI:`DLY_HD_LO];
  wire [7:0]  step   = stp_q[`STP_STEP_HI:`STP_STEP_LO];
  wire [7:0]  intv   = stp_q[`STP_INT_HI:`STP_INT_LO];

  // write path: address and data are taken independently, then applied together
  reg        aw_full_q;
  reg [7:0]  awaddr_q;
  reg        w_full_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready  = ~w_full_q;
  assign s_axi_arready = ~s_axi_rvalid;

  wire do_wr   = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire wr_cfg  = do_wr & (awaddr_q == `OFS_CONFIG);
  wire wr_lim  = do_wr & (awaddr_q == `OFS_LIMITS);
  wire wr_dly  = do_wr & (awaddr_q == `OFS_DELAY);
  wire wr_stp  = do_wr & (awaddr_q == `OFS_STEP);
  wire wr_map  = wr_cfg | wr_lim | wr_dly | wr_stp;
  wire [31:0] cfg_new = merge(cfg_q, wdata_q, wstrb_q, `CFG_MASK | (32'h1 << `CFG_RST));
  wire        cnt_rst = wr_cfg & cfg_new[`CFG_RST];

  // watchdog
  reg  [7:0] wdt_q;
  reg  [7:0] wdt_d;
  wire       wdt_expire = e5 & (wdt_q == `WDT_ONE) & ~wr_cfg & ~(wr_lim & wstrb_q[0]);

  always @* begin
    wdt_d = wdt_q;
    if (wr_cfg)
      wdt_d = cfg_new[`CFG_WDT_HI:`CFG_WDT_LO];
    else if (wr_lim & wstrb_q[0])
      wdt_d = watchdog_reload_value;
    else if (e5 && wdt_q != 8'h00)
      wdt_d = wdt_q - 8'h01;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q          <= 1'b0;
      awaddr_q           <= 8'h00;
      w_full_q           <= 1'b0;
      wdata_q            <= 32'h0;
      wstrb_q            <= 4'h0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `RESP_OKAY;
      cfg_q              <= `CFG_RESET;
      lim_q              <= `LIM_RESET;
      dly_q              <= `DLY_RESET;
      stp_q              <= `STP_RESET;
      wdt_q              <= `WDT_RESET;
      pwm_watchdog_event <= 1'b0;
    end else begin
      if (s_axi_awvalid & ~aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_cfg) cfg_q <= cfg_new & `CFG_MASK;
      if (wr_lim) lim_q <= merge(lim_q, wdata_q, wstrb_q, `LIM_MASK);
      if (wr_dly) dly_q <= merge(dly_q, wdata_q, wstrb_q, `DLY_MASK);
      if (wr_stp) stp_q <= merge(stp_q, wdata_q, wstrb_q, `STP_MASK);
      // expiry only touches the mode field
      if (wdt_expire)
        cfg_q[`CFG_MODE_HI:`CFG_MODE_LO] <= `MODE_ON;
      wdt_q              <= wdt_d;
      pwm_watchdog_event <= wdt_expire;
    end
  end

  // pwm datapath
  reg [7:0]  per_q;
  reg [11:0] pre_q;
  reg [7:0]  duty_q;
  reg [7:0]  icnt_q;
  reg [11:0] hold_q;
  reg [3:0]  st_q;

  // fast clock only for the blink configuration; breathing always uses the slow one
  wire       blink   = (mode == `MODE_BLINK);
  wire       tick    = (blink & csel) ? e48 : e32;
  wire [8:0] up_sum  = {1'b0, duty_q} + {1'b0, step};
  wire [8:0] dn_lim  = {1'b0, dmin} + {1'b0, step};
  wire       wrap    = tick & (per_q == `PERIOD_LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_q  <= 8'h00;
      pre_q  <= 12'h000;
      duty_q <= 8'h00;
      icnt_q <= 8'h00;
      hold_q <= 12'h000;
      st_q   <= ST_UP;
    end else if (cnt_rst || mode == `MODE_OFF || mode == `MODE_ON) begin
      per_q  <= 8'h00;
      pre_q  <= 12'h000;
      duty_q <= dmin;
      icnt_q <= 8'h00;
      hold_q <= 12'h000;
      st_q   <= ST_UP;
    end else if (blink) begin
      if (tick) begin
        if (pre_q == 12'h000) begin
          pre_q <= ld;
          per_q <= per_q + 8'h01;
        end else begin
          pre_q <= pre_q - 12'h001;
        end
      end
    end else begin
      if (tick)
        per_q <= per_q + 8'h01;
      if (wrap) begin
        case (st_q)
          ST_UP: begin
            if (icnt_q != 8'h00) begin
              icnt_q <= icnt_q - 8'h01;
            end else begin
              icnt_q <= intv;
              if (up_sum >= {1'b0, dmax}) begin
                duty_q <= dmax;
                hold_q <= hd;
                st_q   <= ST_HI;
              end else begin
                duty_q <= up_sum[7:0];
              end
            end
          end
          ST_HI: begin
            if (hold_q == 12'h000)
              st_q <= ST_DN;
            else
              hold_q <= hold_q - 12'h001;
          end
          ST_DN: begin
            if (icnt_q != 8'h00) begin
              icnt_q <= icnt_q - 8'h01;
            end else begin
              icnt_q <= intv;
              if ({1'b0, duty_q} <= dn_lim) begin
                duty_q <= dmin;
                hold_q <= ld;
                st_q   <= ST_LO;
              end else begin
                duty_q <= duty_q - step;
              end
            end
          end
          ST_LO: begin
            if (hold_q == 12'h000)
              st_q <= ST_UP;
            else
              hold_q <= hold_q - 12'h001;
          end
          default: st_q <= ST_UP;
        endcase
      end
    end
  end

  // output pin, registered
  reg led_d;
  always @* begin
    case (mode)
      `MODE_ON:      led_d = 1'b1;
      `MODE_BREATHE: led_d = (duty_q == `DUTY_FULL) | (per_q < duty_q);
      // blink duty comes straight from the minimum byte, never altered
      `MODE_BLINK:   led_d = (dmin == `DUTY_FULL) | (per_q < dmin);
      default:       led_d = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      led_out <= 1'b0;
    else
      led_out <= led_d;
  end

  // read path, one cycle latency
  reg [31:0] rd_d;
  reg        rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFS_CONFIG: rd_d = cfg_q;
      `OFS_LIMITS: rd_d = lim_q;
      `OFS_DELAY:  rd_d = dly_q;
      `OFS_STEP:   rd_d = stp_q;
      `OFS_STATUS: rd_d = {4'h0, st_q, per_q, (blink ? dmin : duty_q), wdt_q};
      default: begin
        rd_d  = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: src/led_pwm_defines.vh */
// register map, field positions and reset values of the led blink/breathe pwm
`ifndef LED_PWM_DEFINES_VH
`define LED_PWM_DEFINES_VH

`define OFS_CONFIG      8'h00
`define OFS_LIMITS      8'h04
`define OFS_DELAY       8'h08
`define OFS_STEP        8'h0c
`define OFS_STATUS      8'h10

`define MODE_OFF        2'h0
`define MODE_BREATHE    2'h1
`define MODE_BLINK      2'h2
`define MODE_ON         2'h3

// config: [1:0] mode, [2] clock select (1 = fast, blink mode only), [3] counter reset, [15:8] wdt reload
`define CFG_MODE_LO     0
`define CFG_MODE_HI     1
`define CFG_CSEL        2
`define CFG_RST         3
`define CFG_WDT_LO      8
`define CFG_WDT_HI      15
`define CFG_MASK        32'h0000_ff07
`define CFG_RESET       32'h0000_1400
`define WDT_RESET       8'h14
// limits: [7:0] minimum / blink duty, [15:8] maximum
`define LIM_MIN_LO      0
`define LIM_MIN_HI      7
`define LIM_MAX_LO      8
`define LIM_MAX_HI      15
`define LIM_MASK        32'h0000_ffff
`define LIM_RESET       32'h0000_ff00
// delay: [11:0] delay reload / prescale / low hold, [23:12] high hold
`define DLY_LD_LO       0
`define DLY_LD_HI       11
`define DLY_HD_LO       12
`define DLY_HD_HI       23
`define DLY_MASK        32'h00ff_ffff
`define DLY_RESET       32'h0000_0000
// step: [7:0] duty step, [15:8] ramp interval in periods
`define STP_STEP_LO     0
`define STP_STEP_HI     7
`define STP_INT_LO      8
`define STP_INT_HI      15
`define STP_MASK        32'h0000_ffff
`define STP_RESET       32'h0000_0001

`define DUTY_FULL       8'hff
`define PERIOD_LAST     8'hff
`define WDT_ONE         8'h01
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

/* File: dv/led_pwm_sva.sv */
// port-level assertion checker for the led blink/breathe pwm block
`default_nettype none
module led_pwm_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pin and event
  input wire logic        led_out,
  input wire logic        pwm_watchdog_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // one cycle only, so a stretched pulse is caught
  event_pulse_a: assert property (pwm_watchdog_event |=> !pwm_watchdog_event)
    else $error("watchdog event wider than one cycle");
  event_led_a: assert property (pwm_watchdog_event |-> ##[1:3] led_out)
    else $error("led not forced on after watchdog expiry");
  reset_idle_a: assert property (disable iff (1'b0) !rst_n |-> s_axi_awready && s_axi_wready
    && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !led_out && !pwm_watchdog_event)
    else $error("outputs not idle in reset");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after bready");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after rready");
  w_busy_a: assert property (aw_w_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready while a write is held");
  read_lat_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  write_resp_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
endmodule
`default_nettype wire

/* File: dv/led_load.sv */
// led or fan load: counts clock cycles in which the pin drives it
`default_nettype none
module led_load (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin
  input wire logic led_out,
  output var int   on_cnt
);
  // free-running count; the bench takes differences so no clear is needed
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) on_cnt <= 0;
    else if (led_out) on_cnt <= on_cnt + 1;
  end
endmodule
`default_nettype wire

/* File: dv/led_blink_breathe_pwm_tb.sv */
// testbench: registers, blink and fast pwm duty, watchdog
`include "led_pwm_defines.vh"
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module led_blink_breathe_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, clk_32k, clk_48m, slow_tick_clock, led_out, pwm_watchdog_event;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          on_cnt, fails, cmp_count, ev_cnt, tb_div, c0, per;
  logic [7:0]  ofs [4] = '{`OFS_CONFIG, `OFS_LIMITS, `OFS_DELAY, `OFS_STEP};
  logic [31:0] rv [4] = '{`CFG_RESET, `LIM_RESET, `DLY_RESET, `STP_RESET};
  led_blink_breathe_pwm dut (.clk, .rst_n, .clk_32k, .clk_48m, .slow_tick_clock,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .led_out, .pwm_watchdog_event);
  led_load load (.clk, .rst_n, .led_out, .on_cnt);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // duty ff is forced fully on rather than 255/256
  function automatic int exp_on(input logic [7:0] d, input int p);
    return (d == `DUTY_FULL) ? p : int'(d) * p / 256;
  endfunction
  // breathing {state, duty} after k period wraps, ramp interval zero
  function automatic logic [11:0] breathe_at(input int k, input int mn, mx, st, hi, lo);
    int s, d, h;
    s = 1;
    d = mn;
    h = 0;
    repeat (k) begin
      case (s)
        1: begin
          if (d + st >= mx) begin
            d = mx;
            h = hi;
            s = 2;
          end else d = d + st;
        end
        2: begin
          if (h == 0) s = 4;
          else h--;
        end
        4: begin
          if (d <= mn + st) begin
            d = mn;
            h = lo;
            s = 8;
          end else d = d - st;
        end
        default: begin
          if (h == 0) s = 1;
          else h--;
        end
      endcase
    end
    return {s[3:0], d[7:0]};
  endfunction
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // slow base period 8 clocks, fast base period 6 clocks
  always @(posedge clk) begin
    tb_div <= tb_div + 1;
    if (tb_div % 4 == 3) clk_32k <= ~clk_32k;
    if (tb_div % 3 == 2) clk_48m <= ~clk_48m;
    if (pwm_watchdog_event) ev_cnt <= ev_cnt + 1;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      slow_tick_clock <= 1'b1;
      repeat (6) @(posedge clk);
      slow_tick_clock <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic blink(input logic sel, input logic ld, input logic [7:0] duty);
    wr(`OFS_DELAY, {31'h0, ld}, rsp);
    wr(`OFS_LIMITS, {16'h0, 8'hff, duty}, rsp);
    wr(`OFS_CONFIG, {16'h0, 8'h14, 5'h0, sel, `MODE_BLINK}, rsp);
    per = 256 * (int'(ld) + 1) * (sel ? 6 : 8);
    repeat (64) @(posedge clk);
    c0 = on_cnt;
    repeat (per) @(posedge clk);
    `CHK(on_cnt - c0, exp_on(duty, per))
    rd(`OFS_LIMITS, v, rsp);
    `CHK(v[7:0], duty)
  endtask
  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    close_out();
  end
  initial begin
    {rst_n, clk_32k, clk_48m, slow_tick_clock, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {tb_div, ev_cnt, fails, cmp_count} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    seed = 32'hd8a9;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i], v, rsp);
      `CHK(v, rv[i])
    end
    rd(`OFS_STATUS, v, rsp);
    `CHK(v[7:0], 8'h14)
    rd(8'h14, v, rsp);
    `CHK(rsp, `RESP_SLVERR)
    wr(`OFS_STATUS, 32'h0, rsp);
    `CHK(rsp, `RESP_SLVERR)
    $display("register test done");
    // corners first: duty 00 on slow base, ff on fast base
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      blink(i[0], seed[8], (i < 2) ? {8{i[0]}} : seed[7:0]);
    end
    $display("blink and fast pwm test done");
    wr(`OFS_CONFIG, {16'h0, 8'h02, 5'h0, 1'b1, `MODE_BLINK}, rsp);
    tick(1);
    rd(`OFS_STATUS, v, rsp);
    `CHK(v[7:0], 8'h01)
    repeat (100) @(posedge clk);
    rd(`OFS_STATUS, v, rsp);
    `CHK(v[7:0], 8'h01)
    tick(1);
    `CHK(ev_cnt, 1)
    rd(`OFS_CONFIG, v, rsp);
    `CHK(v, {16'h0, 8'h02, 5'h0, 1'b1, `MODE_ON})
    `CHK(led_out, 1'b1)
    wr(`OFS_CONFIG, {16'h0, 8'h05, 5'h0, 1'b1, `MODE_BLINK}, rsp);
    tick(2);
    rd(`OFS_STATUS, v, rsp);
    `CHK(v[7:0], 8'h03)
    wr(`OFS_LIMITS, 32'h0000_ff40, rsp);
    rd(`OFS_STATUS, v, rsp);
    `CHK(v[7:0], 8'h05)
    wr(`OFS_CONFIG, {16'h0, 8'h00, 5'h0, 1'b1, `MODE_BLINK}, rsp);
    tick(3);
    `CHK(ev_cnt, 1)
    $display("watchdog test done");
    // breathe: min 10, max 30, step 10, high hold 2, low hold 1; sample mid-period
    wr(`OFS_LIMITS, 32'h0000_3010, rsp);
    wr(`OFS_STEP, 32'h0000_0010, rsp);
    wr(`OFS_DELAY, {8'h0, 12'h002, 12'h001}, rsp);
    wr(`OFS_CONFIG, {16'h0, 8'h00, 6'h0, `MODE_OFF}, rsp);
    wr(`OFS_CONFIG, {16'h0, 8'h00, 6'h0, `MODE_BREATHE}, rsp);
    repeat (1024) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      rd(`OFS_STATUS, v, rsp);
      `CHK({v[27:24], v[15:8]}, breathe_at(k, 8'h10, 8'h30, 8'h10, 2, 1))
      repeat (2045) @(posedge clk);
    end
    // counter reset bit restarts the ramp and reads back as zero
    wr(`OFS_CONFIG, {16'h0, 8'h00, 5'h01, 1'b0, `MODE_BREATHE}, rsp);
    rd(`OFS_CONFIG, v, rsp);
    `CHK(v, {16'h0, 8'h00, 6'h0, `MODE_BREATHE})
    rd(`OFS_STATUS, v, rsp);
    `CHK({v[27:24], v[15:8]}, breathe_at(0, 8'h10, 8'h30, 8'h10, 2, 1))
    $display("breathe test done");
    close_out();
  end
endmodule
bind led_blink_breathe_pwm led_pwm_sva chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .led_out, .pwm_watchdog_event);
`default_nettype wire
